// File: rtl/hostaux_pkg.sv
// constants, register map and carriers for the host port auxiliary registers
// assumes a single 20 MHz clock and a byte-wide register port
// How it works
// - shadow status keeps the check flag in bit 0, other bits zero
// - shadow error keeps abort flag in bit 2, seen only in shadow mode
// - diagnostics pin driven to the output bit level while its enable is set
// - diagnostics enable resets to 0; writing 1 turns the driver on
// - dasp pin driven to dasp output bit while dasp enable is set
// - dasp enable resets to 0 so the pin is an input
// - diagnostics input bit shows the pin, valid with enable low, default 0
// - dasp input bit shows the pin, valid with enable low, default 0
// - priority bit ranks host requests second after the microcontroller
// - 32-bit transfer counter decrements with the byte count registers
// - below packet size, counter remainder loads the byte count registers
// - host command write while selected captures byte count into packet store
// - microcontroller may write the packet size store directly
// - byte count reloads from packet store when counter not below it
// - suspend bit freezes the auto sequencer in its present state
// - sequencer status register returns the state number in bits 5 to 0
// - a suspended register write waits until suspend is cleared
// - completion sequence first copies error request into alternate check bit
package hostaux_pkg;
	localparam logic [15:0] ADDR_SHADOW_STATUS = 16'hff97;
	localparam logic [15:0] ADDR_SHADOW_ERROR  = 16'hff98;
	localparam logic [15:0] ADDR_PIN_PRIO      = 16'hff99;
	localparam logic [15:0] ADDR_XFER_B0       = 16'hffa0;
	localparam logic [15:0] ADDR_XFER_B1       = 16'hffa1;
	localparam logic [15:0] ADDR_XFER_B2       = 16'hffa2;
	localparam logic [15:0] ADDR_XFER_B3       = 16'hffa3;
	localparam logic [15:0] ADDR_PKT_LO        = 16'hffa4;
	localparam logic [15:0] ADDR_PKT_HI        = 16'hffa5;
	localparam logic [15:0] ADDR_SEQ_STATE     = 16'hffa6;
	localparam logic [15:0] ADDR_SEQ_CTRL      = 16'hffa7;
	localparam int SHCHECK_BIT  = 0;
	localparam int SHABRT_BIT   = 2;
	localparam int PDIAG_OUT    = 7;
	localparam int PDIAG_EN     = 6;
	localparam int DASP_OUT     = 5;
	localparam int DASP_EN      = 4;
	localparam int PDIAG_IN     = 3;
	localparam int DASP_IN      = 2;
	localparam int HOST_HIPRI   = 0;
	localparam int SUSPEND_BIT  = 4;
	localparam int ERROR_BIT    = 3;
	localparam int COMP_BIT     = 5;
	localparam logic [7:0] PIN_PRIO_RESET = 8'h00;
	localparam logic [7:0] SEQ_CTRL_RESET = 8'h00;

	typedef enum logic [1:0] {PRIO_LOW, PRIO_SECOND} host_prio_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic cmd_wr;
		logic sel;
		logic rd_slave_status;
		logic rd_slave_error;
		logic shadow_mode;
	} host_evt_t;
endpackage : hostaux_pkg

// File: rtl/hostaux_regs.sv
// host port auxiliary registers: shadow regs, pins, priority, counters, sequencer
// assumes register port and host events on clk; pins are asynchronous
//
// Implementation choice: strobed register access.
module hostaux_regs
	import hostaux_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire reg_req_t    req,
	output logic [7:0]       rdata,
	input  wire host_evt_t   host_evt,
	output logic [7:0]       host_rdata,
	input  wire logic        byte_moved,
	output logic [15:0]      byte_count,
	input  wire logic        seq_step,
	input  wire logic [5:0]  seq_next_state,
	input  wire logic        seq_reg_wr,
	input  wire logic        seq_comp_start,
	output logic             seq_reg_wr_go,
	output logic             alt_check,
	output logic             host_prio_second,
	input  wire logic        pdiag_in,
	output logic             pdiag_out,
	output logic             pdiag_oe,
	input  wire logic        dasp_in,
	output logic             dasp_out,
	output logic             dasp_oe
);
	// =========================================================
	// state
	logic [7:0]  shadow_status_r, shadow_error_r, pinctl_r, seqctl_r, rdata_r, hrd_r;
	logic [31:0] xfer_r;
	logic [15:0] pkt_r, bc_r;
	logic [5:0]  seq_state_r;
	logic        wr_pend_r, wr_go_r, alt_chk_r;
	logic        pd_s1, pd_s2, da_s1, da_s2;

	// =========================================================
	// decode
	wire wr_shst  = req.wr && req.addr == ADDR_SHADOW_STATUS;
	wire wr_sher  = req.wr && req.addr == ADDR_SHADOW_ERROR;
	wire wr_pin   = req.wr && req.addr == ADDR_PIN_PRIO;
	wire wr_x0    = req.wr && req.addr == ADDR_XFER_B0;
	wire wr_x1    = req.wr && req.addr == ADDR_XFER_B1;
	wire wr_x2    = req.wr && req.addr == ADDR_XFER_B2;
	wire wr_x3    = req.wr && req.addr == ADDR_XFER_B3;
	wire wr_plo   = req.wr && req.addr == ADDR_PKT_LO;
	wire wr_phi   = req.wr && req.addr == ADDR_PKT_HI;
	wire wr_sqc   = req.wr && req.addr == ADDR_SEQ_CTRL;
	wire suspend  = seqctl_r[SUSPEND_BIT];
	wire xfer_wr  = wr_x0 | wr_x1 | wr_x2 | wr_x3;
	wire capture  = host_evt.cmd_wr && host_evt.sel;
	wire count_on = byte_moved && bc_r != 16'h0000 && xfer_r != 32'h0000_0000;
	wire [31:0] xfer_dec = xfer_r - 32'h0000_0001;
	wire [15:0] bc_dec   = bc_r - 16'h0001;
	wire pkt_empty = bc_dec == 16'h0000;
	wire xfer_ge   = xfer_dec >= {16'h0000, pkt_r};
	// empty byte count with work left: start the next packet
	wire bc_load   = bc_r == 16'h0000 && xfer_r != 32'h0000_0000 && !xfer_wr;
	wire xfer_now_ge = xfer_r >= {16'h0000, pkt_r};

	// =========================================================
	// read mux
	wire [7:0] pin_view = {pinctl_r[7:4], pd_s2, da_s2, 1'b0, pinctl_r[HOST_HIPRI]};
	logic [7:0] rd_mux;
	always_comb begin
		case (req.addr)
			ADDR_PIN_PRIO:  rd_mux = pin_view;
			ADDR_XFER_B0:   rd_mux = xfer_r[7:0];
			ADDR_XFER_B1:   rd_mux = xfer_r[15:8];
			ADDR_XFER_B2:   rd_mux = xfer_r[23:16];
			ADDR_XFER_B3:   rd_mux = xfer_r[31:24];
			ADDR_PKT_LO:    rd_mux = pkt_r[7:0];
			ADDR_PKT_HI:    rd_mux = pkt_r[15:8];
			ADDR_SEQ_STATE: rd_mux = {2'b00, seq_state_r};
			ADDR_SEQ_CTRL:  rd_mux = seqctl_r;
			default:        rd_mux = 8'h00;
		endcase
	end

	wire shadow_rd_st = host_evt.shadow_mode && host_evt.rd_slave_status;
	wire shadow_rd_er = host_evt.shadow_mode && host_evt.rd_slave_error;
	wire [7:0] hrd_nxt = shadow_rd_st ? shadow_status_r : (shadow_rd_er ? shadow_error_r : 8'h00);

	// =========================================================
	// register port and pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shadow_status_r <= 8'h00;
			shadow_error_r  <= 8'h00;
			pinctl_r <= PIN_PRIO_RESET;
			seqctl_r <= SEQ_CTRL_RESET;
			rdata_r  <= 8'h00;
			hrd_r    <= 8'h00;
			pd_s1    <= 1'b0;
			pd_s2    <= 1'b0;
			da_s1    <= 1'b0;
			da_s2    <= 1'b0;
		end else begin
			if (wr_shst)
				shadow_status_r <= {7'h00, req.wdata[SHCHECK_BIT]};
			if (wr_sher)
				shadow_error_r <= {5'h00, req.wdata[SHABRT_BIT], 2'b00};
			if (wr_pin)
				pinctl_r <= {req.wdata[7:4], 3'b000, req.wdata[HOST_HIPRI]};
			if (wr_sqc)
				seqctl_r <= req.wdata;
			rdata_r <= req.rd ? rd_mux : 8'h00;
			hrd_r   <= hrd_nxt;
			pd_s1   <= pdiag_in;
			pd_s2   <= pd_s1;
			da_s1   <= dasp_in;
			da_s2   <= da_s1;
		end
	end

	// =========================================================
	// transfer counter, byte count, packet store
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xfer_r <= 32'h0000_0000;
			pkt_r  <= 16'h0000;
			bc_r   <= 16'h0000;
		end else begin
			if (xfer_wr) begin
				if (wr_x0) xfer_r[7:0]   <= req.wdata;
				if (wr_x1) xfer_r[15:8]  <= req.wdata;
				if (wr_x2) xfer_r[23:16] <= req.wdata;
				if (wr_x3) xfer_r[31:24] <= req.wdata;
			end else if (count_on)
				xfer_r <= xfer_dec;
			if (wr_plo)
				pkt_r[7:0] <= req.wdata;
			else if (capture)
				pkt_r[7:0] <= bc_r[7:0];
			if (wr_phi)
				pkt_r[15:8] <= req.wdata;
			else if (capture)
				pkt_r[15:8] <= bc_r[15:8];
			if (capture)
				bc_r <= bc_r;
			else if (count_on) begin
				if (!pkt_empty)
					bc_r <= bc_dec;
				else if (xfer_ge)
					bc_r <= pkt_r;
				else
					bc_r <= xfer_dec[15:0];
			end else if (bc_load) begin
				if (xfer_now_ge)
					bc_r <= pkt_r;
				else
					bc_r <= xfer_r[15:0];
			end
		end
	end

	// =========================================================
	// sequencer hold, deferred write, completion check copy
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_state_r <= 6'h00;
			wr_pend_r   <= 1'b0;
			wr_go_r     <= 1'b0;
			alt_chk_r   <= 1'b0;
		end else begin
			if (seq_step && !suspend)
				seq_state_r <= seq_next_state;
			wr_go_r <= 1'b0;
			if (suspend) begin
				if (seq_reg_wr)
					wr_pend_r <= 1'b1;
			end else if (wr_pend_r || seq_reg_wr) begin
				wr_go_r   <= 1'b1;
				wr_pend_r <= 1'b0;
			end
			if (seq_comp_start && seqctl_r[COMP_BIT] && !suspend)
				alt_chk_r <= seqctl_r[ERROR_BIT];
		end
	end

	// =========================================================
	// outputs
	assign rdata            = rdata_r;
	assign host_rdata       = hrd_r;
	assign byte_count       = bc_r;
	assign seq_reg_wr_go    = wr_go_r;
	assign alt_check        = alt_chk_r;
	assign host_prio_second = pinctl_r[HOST_HIPRI];
	assign pdiag_out        = pinctl_r[PDIAG_OUT];
	assign pdiag_oe         = pinctl_r[PDIAG_EN];
	assign dasp_out         = pinctl_r[DASP_OUT];
	assign dasp_oe          = pinctl_r[DASP_EN];
endmodule : hostaux_regs

// File: testbench/hostaux_regs_props.sv
// checker for the host port auxiliary registers
// assumes it is bound into hostaux_regs
module hostaux_regs_props
	import hostaux_pkg::*;
(
	input wire logic       clk,
	input wire logic       arst_n,
	input wire reg_req_t   req,
	input wire logic [7:0] rdata,
	input wire host_evt_t  host_evt,
	input wire logic [7:0] host_rdata,
	input wire logic       seq_comp_start,
	input wire logic       seq_reg_wr_go,
	input wire logic       alt_check,
	input wire logic       host_prio_second,
	input wire logic       pdiag_out,
	input wire logic       pdiag_oe,
	input wire logic       dasp_out,
	input wire logic       dasp_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [7:0] ctl_r;
	wire        hw = req.wr && req.addr == ADDR_PIN_PRIO;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			ctl_r <= 8'h00;
		else if (req.wr && req.addr == ADDR_SEQ_CTRL)
			ctl_r <= req.wdata;
	pdiag_en_a: assert property (hw |=> pdiag_oe == $past(req.wdata[PDIAG_EN]))
		else $error("pdiag enable");
	pdiag_lvl_a: assert property (hw |=> pdiag_out == $past(req.wdata[PDIAG_OUT]))
		else $error("pdiag level");
	dasp_drv_a: assert property (hw |=> {dasp_out, dasp_oe} == $past(req.wdata[5:4]))
		else $error("dasp drive");
	host_prio_a: assert property (hw |=> host_prio_second == $past(req.wdata[HOST_HIPRI]))
		else $error("priority");
	seq_top_a: assert property (req.rd && req.addr == ADDR_SEQ_STATE |=> rdata[7:6] == 2'b00)
		else $error("state high bits");
	sh_status_a: assert property (host_evt.rd_slave_status && host_evt.shadow_mode |=> host_rdata[7:1] == 7'h00)
		else $error("shadow status bits");
	sh_error_a: assert property (host_evt.rd_slave_error && !host_evt.shadow_mode |=> host_rdata == 8'h00)
		else $error("shadow error seen");
	wr_hold_a: assert property (ctl_r[SUSPEND_BIT] && $past(ctl_r[SUSPEND_BIT]) |-> !seq_reg_wr_go)
		else $error("write while suspended");
	comp_chk_a: assert property (seq_comp_start && ctl_r[COMP_BIT] && !ctl_r[SUSPEND_BIT]
		|=> alt_check == $past(ctl_r[ERROR_BIT]))
		else $error("check bit copy");
endmodule : hostaux_regs_props
bind hostaux_regs hostaux_regs_props chk (.*);

// File: testbench/ide_cable_model.sv
// far side of the pins: pull-ups plus another drive that may pull low
// assumes pins split into level and enable
module ide_cable_model (
	input  wire logic pdiag_out,
	input  wire logic pdiag_oe,
	input  wire logic dasp_out,
	input  wire logic dasp_oe,
	input  wire logic other_low,
	output logic      pdiag_in,
	output logic      dasp_in
);
	assign pdiag_in = other_low ? 1'b0 : (pdiag_oe ? pdiag_out : 1'b1);
	assign dasp_in  = other_low || (dasp_oe && !dasp_out) ? 1'b0 : 1'b1;
endmodule : ide_cable_model

// File: testbench/hostaux_regs_tb.sv
// self-checking bench for the host port auxiliary registers
// assumes the checker and cable model are compiled alongside
module hostaux_regs_tb
	import hostaux_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	reg_req_t   req = '0;
	host_evt_t  host_evt = '0;
	logic       byte_moved = 1'b0, seq_step = 1'b0, seq_reg_wr = 1'b0, seq_comp_start = 1'b0, other_low = 1'b0;
	logic [5:0] seq_next_state = 6'h00;
	logic [7:0] rdata, host_rdata;
	logic [15:0] byte_count;
	logic       seq_reg_wr_go, alt_check, host_prio_second, pdiag_in, pdiag_out, pdiag_oe, dasp_in, dasp_out, dasp_oe;
	int         mismatches = 0, checks = 0, cyc = 0, gos = 0;
	hostaux_regs dut (.*);
	ide_cable_model cable (.*);
	initial forever #25 clk = ~clk;
	always @(negedge clk) if (seq_reg_wr_go === 1'b1) gos++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		chk(rdata & m, e);
		@(posedge clk);
	endtask : rd
	task automatic hr(input host_evt_t v, input logic [7:0] e);
		host_evt <= v;
		@(posedge clk);
		host_evt <= '0;
		@(negedge clk);
		chk(host_rdata, e);
		@(posedge clk);
	endtask : hr
	task automatic sig(input logic [3:0] v);
		{seq_step, seq_reg_wr, seq_comp_start, byte_moved} <= v;
		@(posedge clk);
		{seq_step, seq_reg_wr, seq_comp_start, byte_moved} <= 4'h0;
		@(negedge clk);
	endtask : sig
	task automatic t_pins;
		rd(ADDR_PIN_PRIO, 8'hf1, 8'h00);
		rd(16'hff9a, 8'hff, 8'h00);
		wr(ADDR_PIN_PRIO, 8'h50);
		chk({6'h00, pdiag_in, dasp_in}, 8'h00);
		wr(ADDR_PIN_PRIO, 8'hc1);
		chk({5'h00, pdiag_in, dasp_in, host_prio_second}, 8'h07);
		wr(ADDR_PIN_PRIO, 8'h20);
		other_low <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ADDR_PIN_PRIO, 8'hfd, 8'h20);
		other_low <= 1'b0;
		repeat (3) @(posedge clk);
		rd(ADDR_PIN_PRIO, 8'hfd, 8'h2c);
	endtask : t_pins
	task automatic t_shadow;
		wr(ADDR_SHADOW_STATUS, 8'hff);
		wr(ADDR_SHADOW_ERROR, 8'hff);
		hr(5'b00101, 8'h01);
		hr(5'b00011, 8'h04);
		hr(5'b00010, 8'h00);
	endtask : t_shadow
	task automatic t_packet;
		logic [4:0][7:0] bc_exp;
		bc_exp = {8'h01, 8'h02, 8'h01, 8'h01, 8'h00};
		wr(ADDR_PKT_LO, 8'h02);
		wr(ADDR_XFER_B0, 8'h05);
		@(negedge clk);
		chk(byte_count, 16'h0002);
		@(posedge clk);
		for (int k = 0; k < 5; k++) begin
			sig(4'h1);
			chk(byte_count, 16'(bc_exp[4 - k]));
			@(posedge clk);
		end
		rd(ADDR_XFER_B0, 8'hff, 8'h00);
	endtask : t_packet
	task automatic t_count;
		for (int i = 0; i < 4; i++) wr(ADDR_XFER_B0 + 16'(i), 8'(8'h11 * (i + 1)));
		wr(ADDR_PKT_HI, 8'h12);
		for (int i = 0; i < 4; i++) rd(ADDR_XFER_B0 + 16'(i), 8'hff, 8'(8'h11 * (i + 1)));
		rd(ADDR_PKT_HI, 8'hff, 8'h12);
		hr(5'b11000, 8'h00);
		rd(ADDR_PKT_HI, 8'hff, 8'h00);
		rd(ADDR_PKT_LO, 8'hff, 8'h02);
		chk(byte_count, 16'h0002);
	endtask : t_count
	task automatic t_seq;
		seq_next_state <= 6'h2a;
		wr(ADDR_SEQ_CTRL, 8'h10);
		sig(4'hc);
		chk(8'(gos), 8'h00);
		@(posedge clk);
		rd(ADDR_SEQ_STATE, 8'hff, 8'h00);
		wr(ADDR_SEQ_CTRL, 8'h00);
		sig(4'h8);
		chk(8'(gos), 8'h01);
		@(posedge clk);
		rd(ADDR_SEQ_STATE, 8'hff, 8'h2a);
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_SEQ_CTRL, k == 0 ? 8'h28 : 8'h20);
			sig(4'h2);
			chk({7'h00, alt_check}, k == 0 ? 8'h01 : 8'h00);
			@(posedge clk);
		end
	endtask : t_seq
	task automatic results;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_pins();
		t_shadow();
		t_packet();
		t_count();
		t_seq();
		results();
	end
endmodule : hostaux_regs_tb
